// ===== hw/ecwtl_filt.sv
// Purpose: Two-stage synchroniser and stability filter for the encoder inputs
// Assumes: One sample per clk_sys edge
// Notes:   A new level is taken only after it stands for the full stable count
`timescale 1ns/1ps
module ecwtl_filt #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Pins
    ecwtl_pin_if.filt pins
);
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] clean;
    logic [WIDTH-1:0] next_clean;
    logic [3:0]       cnt      [WIDTH];
    logic [3:0]       next_cnt [WIDTH];
    logic [3:0]       thr;

    assign thr        = pins.filter_en ? ecwtl_pkg::FILT_LONG : ecwtl_pkg::FILT_SHORT; // RQ17
    assign pins.clean = clean;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_clean[i] = clean[i];
            next_cnt[i]   = 4'h0;
            if (sync2[i] != clean[i]) begin
                if (cnt[i] == thr - 4'h1) begin // RQ17
                    next_clean[i] = sync2[i];
                end else begin
                    next_cnt[i] = cnt[i] + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        sync1 <= pins.raw;
        sync2 <= sync1;
        if (rst) begin
            clean <= '0;
            for (int i = 0; i < WIDTH; i++) begin
                cnt[i] <= 4'h0;
            end
        end else begin
            clean <= next_clean;
            for (int i = 0; i < WIDTH; i++) begin
                cnt[i] <= next_cnt[i];
            end
        end
    end

    AST_FILT_STABLE: assert property (@(posedge clk_sys) disable iff (rst) // RQ17
        (clean[0] != $past(clean[0])) |-> ($past(cnt[0]) == $past(thr) - 4'h1))
        else $error("Filtered input changed before its stable count");
endmodule : ecwtl_filt

// ===== hw/ecwtl_pin_if.sv
// Purpose: Encoder pin bundle between the core and its input filter
// Assumes: Bit 0 A, bit 1 B, bit 2 index, bit 3 index mask
// Notes:   raw is asynchronous to clk_sys; clean is synchronised and filtered
`timescale 1ns/1ps
interface ecwtl_pin_if;
    logic [3:0] raw;
    logic [3:0] clean;
    logic       filter_en;
    modport filt (input raw, input filter_en, output clean);
    modport core (output raw, output filter_en, input clean);
endinterface : ecwtl_pin_if

// ===== hw/ecwtl_pkg.sv
// Purpose: Shared constants for the encoder counter with timed latch
// Assumes: 20 MHz system clock, byte addressed register map, one word per register
// Notes:   Offsets are byte addresses; bits [1:0] of the bus address are ignored
package ecwtl_pkg;
    // Clock and time base
    localparam int CLK_HZ           = 20_000_000;
    localparam int HZ_PER_MHZ       = 1_000_000;
    localparam int CLK_PER_US       = CLK_HZ / HZ_PER_MHZ;
    localparam int THREAD_PERIOD_US = 1000;
    localparam int BASE_PERIOD_CYC  = THREAD_PERIOD_US * CLK_PER_US;

    // Register byte offsets
    localparam logic [5:0] ADDR_CTRL        = 6'h00;
    localparam logic [5:0] ADDR_COUNT       = 6'h04;
    localparam logic [5:0] ADDR_TOTAL       = 6'h08;
    localparam logic [5:0] ADDR_LATCH_SEL   = 6'h0c;
    localparam logic [5:0] ADDR_SYNC        = 6'h10;
    localparam logic [5:0] ADDR_BASE_PERIOD = 6'h14;
    localparam logic [5:0] ADDR_TIME_CONST  = 6'h18;
    localparam logic [5:0] ADDR_PHASE_LIMIT = 6'h1c;
    localparam logic [5:0] ADDR_PRESCALE    = 6'h20;
    localparam logic [5:0] ADDR_PHASE_ERR   = 6'h24;
    localparam logic [5:0] ADDR_OFFSET0     = 6'h28;
    localparam logic [5:0] ADDR_SERIAL_SEL  = 6'h38;

    // Control register fields
    localparam int CB_COUNT_RESET = 0;
    localparam int CB_INDEX_ARM   = 1;
    localparam int CB_INDEX_RISE  = 2;
    localparam int CB_GATE_EN     = 3;
    localparam int CB_GATE_LOW    = 4;
    localparam int CB_STEP_DIR    = 5;
    localparam int CB_FILTER_EN   = 6;
    localparam int CB_INDEX_SEEN  = 7;

    // Reset values
    localparam logic        FILTER_EN_RST   = 1'b1;
    localparam logic [2:0]  LATCH_SEL_RST   = 3'h7;
    localparam logic [31:0] TIME_CONST_RST  = 32'h0000_07d0;
    localparam logic [31:0] PHASE_LIMIT_RST = 32'h0040_0000;
    localparam logic [15:0] PRESCALE_RST    = 16'h0001;

    // Input filter stable-sample counts
    localparam logic [3:0] FILT_LONG  = 4'hf;
    localparam logic [3:0] FILT_SHORT = 4'h3;

    // Loop constants
    localparam int NUM_TIMERS  = 4;
    localparam int PHASE_SHIFT = 3;
endpackage : ecwtl_pkg

// ===== hw/ecwtl_top.sv
// Purpose: Encoder counter with index handling and a host-locked trigger timer unit
// Assumes: Avalon-MM slave, byte addresses, encoder pins asynchronous to clk_sys
// Notes:   A read of the count register marks the host read instant
// Summary of operation
// RQ1 - Four timers fire at signed microsecond offsets
// RQ2 - Lock to host reads; zero limit free-runs
// RQ3 - Filter time constant paces period trim
// RQ4 - Rate generator divided by prescale factor
// RQ5 - Phase error reported in microseconds
// RQ6 - Selected timer starts serial encoder transfer
// RQ7 - Host programs roughly minus 100 microsecond offsets
// RQ8 - Latch select: disabled, host write, timer
// RQ9 - Inputs A, B, index, optional index mask
// RQ10 - Count reset level holds count zero
// RQ11 - Armed index zeroes count, clears arm
// RQ12 - Total count never reset or zeroed
// RQ13 - Edge select picks rising or falling index
// RQ14 - Gating makes index need active mask
// RQ15 - Gate polarity picks low or high mask
// RQ16 - Source select: quadrature or step/direction
// RQ17 - Filter needs 15 or 3 stable samples
// RQ18 - Inputs sampled on the sample clock
// RQ19 - Quadrature counts each edge, 32-bit wrap
// RQ20 - Latched count returned to host read
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module ecwtl_top #(
    parameter int   BASE_PERIOD_DEF = ecwtl_pkg::BASE_PERIOD_CYC,
    parameter logic HAS_INDEX_MASK  = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Encoder pins
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_index,
    input  wire logic        enc_index_mask,
    // Trigger outputs
    output logic      [3:0]  trigger_fire,
    output logic             serial_start
);
    localparam int NT = ecwtl_pkg::NUM_TIMERS;

    ecwtl_pin_if pin_if ();
    ecwtl_filt #(.WIDTH(4)) u_filt (.clk_sys(clk_sys), .rst(rst), .pins(pin_if.filt)); // RQ18
    assign pin_if.raw = {enc_index_mask, enc_index, enc_b, enc_a}; // RQ9

    // Bus
    logic [5:0]  wa;
    logic        wr;
    logic        rd_cnt_ev;
    logic        next_wait;
    logic [31:0] next_rdata;
    // Configuration
    logic               count_reset, index_rise, gate_en, gate_low, step_dir, filter_en;
    logic               next_count_reset, next_index_rise, next_gate_en, next_gate_low;
    logic               next_step_dir, next_filter_en;
    logic        [2:0]  latch_sel, next_latch_sel;
    logic        [31:0] base_period, next_base_period;
    logic        [31:0] time_const, next_time_const;
    logic        [31:0] phase_limit, next_phase_limit;
    logic        [15:0] prescale, next_prescale;
    logic signed [15:0] trigger_offset_us      [NT];
    logic signed [15:0] next_trigger_offset_us [NT];
    logic        [1:0]  serial_sel, next_serial_sel;
    // Encoder
    logic               prev_a, prev_b, prev_idx;
    logic               arm, next_arm, seen, next_seen;
    logic signed [31:0] count, next_count, total, next_total, held, next_held, delta;
    logic               idx_q;
    // Loop
    logic        [15:0] pre_cnt, next_pre_cnt;
    logic        [31:0] phase, next_phase, period;
    logic signed [31:0] trim, next_trim, acc, next_acc, err, nudged, lim;
    logic signed [31:0] loop_phase_error, next_loop_phase_error;
    logic        [31:0] tgt [NT];
    logic               tick;
    logic        [3:0]  next_fire;
    logic               next_serial;

    assign wa        = {avs_address[5:2], 2'b00};
    assign wr        = avs_write && !avs_waitrequest;
    assign rd_cnt_ev = avs_read && !avs_waitrequest && (wa == ecwtl_pkg::ADDR_COUNT); // RQ2
    assign pin_if.filter_en = filter_en;

    // Bus answer one cycle after a request appears
    always_comb begin
        next_wait  = 1'b1;
        next_rdata = avs_readdata;
        if ((avs_read || avs_write) && avs_waitrequest) begin
            next_wait  = 1'b0;
            next_rdata = 32'h0;
            if (wa == ecwtl_pkg::ADDR_CTRL) begin
                next_rdata = {24'h0, seen, filter_en, step_dir, gate_low, gate_en,
                              index_rise, arm, count_reset};
            end else if (wa == ecwtl_pkg::ADDR_COUNT) begin
                next_rdata = (latch_sel <= 3'h4) ? held : count; // RQ20
            end else if (wa == ecwtl_pkg::ADDR_TOTAL) begin
                next_rdata = total;
            end else if (wa == ecwtl_pkg::ADDR_LATCH_SEL) begin
                next_rdata = {{29{latch_sel[2]}}, latch_sel};
            end else if (wa == ecwtl_pkg::ADDR_BASE_PERIOD) begin
                next_rdata = base_period;
            end else if (wa == ecwtl_pkg::ADDR_TIME_CONST) begin
                next_rdata = time_const;
            end else if (wa == ecwtl_pkg::ADDR_PHASE_LIMIT) begin
                next_rdata = phase_limit;
            end else if (wa == ecwtl_pkg::ADDR_PRESCALE) begin
                next_rdata = {16'h0, prescale};
            end else if (wa == ecwtl_pkg::ADDR_PHASE_ERR) begin
                next_rdata = loop_phase_error; // RQ5
            end else if (wa[5:4] == 2'b10 || wa == 6'h2c || wa == 6'h30 || wa == 6'h34) begin
                next_rdata = {{16{trigger_offset_us[2'(wa[5:2] - 4'ha)][15]}},
                              trigger_offset_us[2'(wa[5:2] - 4'ha)]};
            end else if (wa == ecwtl_pkg::ADDR_SERIAL_SEL) begin
                next_rdata = {30'h0, serial_sel};
            end
        end
    end

    // Configuration writes
    always_comb begin
        next_count_reset = count_reset;
        next_index_rise  = index_rise;
        next_gate_en     = gate_en;
        next_gate_low    = gate_low;
        next_step_dir    = step_dir;
        next_filter_en   = filter_en;
        next_latch_sel   = latch_sel;
        next_base_period = base_period;
        next_time_const  = time_const;
        next_phase_limit = phase_limit;
        next_prescale    = prescale;
        next_serial_sel  = serial_sel;
        for (int i = 0; i < NT; i++) begin
            next_trigger_offset_us[i] = trigger_offset_us[i];
        end
        if (wr) begin
            if (wa == ecwtl_pkg::ADDR_CTRL) begin
                next_count_reset = avs_writedata[ecwtl_pkg::CB_COUNT_RESET];
                next_index_rise  = avs_writedata[ecwtl_pkg::CB_INDEX_RISE];
                next_gate_en     = avs_writedata[ecwtl_pkg::CB_GATE_EN];
                next_gate_low    = avs_writedata[ecwtl_pkg::CB_GATE_LOW];
                next_step_dir    = avs_writedata[ecwtl_pkg::CB_STEP_DIR];
                next_filter_en   = avs_writedata[ecwtl_pkg::CB_FILTER_EN];
            end else if (wa == ecwtl_pkg::ADDR_LATCH_SEL) begin
                next_latch_sel = avs_writedata[2:0];
            end else if (wa == ecwtl_pkg::ADDR_BASE_PERIOD) begin
                next_base_period = avs_writedata;
            end else if (wa == ecwtl_pkg::ADDR_TIME_CONST) begin
                next_time_const = avs_writedata;
            end else if (wa == ecwtl_pkg::ADDR_PHASE_LIMIT) begin
                next_phase_limit = avs_writedata;
            end else if (wa == ecwtl_pkg::ADDR_PRESCALE) begin
                next_prescale = avs_writedata[15:0];
            end else if (wa[5:2] >= 4'ha && wa[5:2] <= 4'hd) begin
                next_trigger_offset_us[2'(wa[5:2] - 4'ha)] = avs_writedata[15:0];
            end else if (wa == ecwtl_pkg::ADDR_SERIAL_SEL) begin
                next_serial_sel = avs_writedata[1:0];
            end
        end
    end

    // Encoder decode and counting
    always_comb begin
        logic a, b, idx, mask_ok, edge_ok;
        a     = pin_if.clean[0];
        b     = pin_if.clean[1];
        idx   = pin_if.clean[2];
        edge_ok = index_rise ? (idx && !prev_idx) : (!idx && prev_idx); // RQ13
        mask_ok = !HAS_INDEX_MASK || (pin_if.clean[3] == !gate_low); // RQ15
        delta = 32'sh0;
        if (step_dir) begin
            if (a && !prev_a) begin // RQ16
                delta = b ? 32'sh1 : -32'sh1;
            end
        end else if ((a ^ prev_a) != (b ^ prev_b)) begin // RQ19
            delta = (a ^ prev_b) ? 32'sh1 : -32'sh1;
        end
        idx_q   = edge_ok && (!gate_en || mask_ok); // RQ14
        next_count = count + delta; // RQ19
        next_total = total + delta; // RQ12
        next_arm   = arm;
        next_seen  = seen;
        if (arm && idx_q) begin // RQ11
            next_count = 32'sh0;
            next_arm   = 1'b0;
            next_seen  = 1'b1;
        end
        if (count_reset) begin // RQ10
            next_count = 32'sh0;
        end
        if (wr && wa == ecwtl_pkg::ADDR_CTRL) begin
            next_arm = avs_writedata[ecwtl_pkg::CB_INDEX_ARM];
            if (avs_writedata[ecwtl_pkg::CB_INDEX_SEEN] && !(arm && idx_q)) begin
                next_seen = 1'b0;
            end
        end
        next_held = held;
        if (latch_sel == 3'h0 && wr && wa == ecwtl_pkg::ADDR_SYNC) begin // RQ8
            next_held = count;
        end else if (latch_sel >= 3'h1 && latch_sel <= 3'h4 && trigger_fire[2'(latch_sel - 3'h1)]) begin
            next_held = count; // RQ20
        end
    end

    // Trigger loop
    always_comb begin
        logic [31:0] half;
        lim    = $signed(phase_limit);
        period = base_period + $unsigned(trim);
        half   = period >> 1;
        tick   = (pre_cnt + 16'h1 >= prescale); // RQ4
        next_pre_cnt = tick ? 16'h0 : pre_cnt + 16'h1;
        next_phase   = phase;
        if (tick) begin
            next_phase = (phase + 32'h1 >= period) ? 32'h0 : phase + 32'h1;
        end
        err    = (phase < half) ? $signed(phase) : $signed(phase) - $signed(period);
        nudged = $signed(phase) - (err >>> ecwtl_pkg::PHASE_SHIFT);
        next_trim = trim;
        next_acc  = acc;
        next_loop_phase_error = loop_phase_error;
        if (rd_cnt_ev) begin
            next_loop_phase_error = err / ecwtl_pkg::CLK_PER_US; // RQ5
            if (phase_limit != 32'h0) begin
                next_acc = acc + err; // RQ3
                if (next_acc >= $signed(time_const)) begin
                    next_acc  = next_acc - $signed(time_const);
                    next_trim = trim + 32'sh1;
                end else if (next_acc <= -$signed(time_const)) begin
                    next_acc  = next_acc + $signed(time_const);
                    next_trim = trim - 32'sh1;
                end
                if (nudged >= $signed(period)) begin // RQ2
                    next_phase = 32'(nudged - $signed(period));
                end else if (nudged < 32'sh0) begin
                    next_phase = 32'(nudged + $signed(period));
                end else begin
                    next_phase = 32'(nudged);
                end
            end
        end
        if (next_trim > lim) begin
            next_trim = lim;
        end else if (next_trim < -lim) begin
            next_trim = -lim;
        end
        if (phase_limit == 32'h0) begin // RQ2
            next_trim = 32'sh0;
            next_acc  = 32'sh0;
        end
        for (int i = 0; i < NT; i++) begin
            logic signed [31:0] off;
            off    = 32'(int'(trigger_offset_us[i]) * ecwtl_pkg::CLK_PER_US);
            tgt[i] = (off < 0) ? 32'($signed(period) + off) : 32'(off); // RQ1
            next_fire[i] = tick && (phase == tgt[i]);
        end
        next_serial = next_fire[serial_sel]; // RQ6
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest  <= 1'b1;
            avs_readdata     <= 32'h0;
            count_reset      <= 1'b0;
            index_rise       <= 1'b0;
            gate_en          <= 1'b0;
            gate_low         <= 1'b0;
            step_dir         <= 1'b0;
            filter_en        <= ecwtl_pkg::FILTER_EN_RST;
            latch_sel        <= ecwtl_pkg::LATCH_SEL_RST;
            base_period      <= 32'(BASE_PERIOD_DEF);
            time_const       <= ecwtl_pkg::TIME_CONST_RST;
            phase_limit      <= ecwtl_pkg::PHASE_LIMIT_RST;
            prescale         <= ecwtl_pkg::PRESCALE_RST;
            serial_sel       <= 2'h0;
            for (int i = 0; i < NT; i++) begin
                trigger_offset_us[i] <= 16'sh0;
            end
            {prev_a, prev_b, prev_idx} <= 3'h0;
            {arm, seen}      <= 2'h0;
            count            <= 32'sh0;
            total            <= 32'sh0;
            held             <= 32'sh0;
            pre_cnt          <= 16'h0;
            phase            <= 32'h0;
            trim             <= 32'sh0;
            acc              <= 32'sh0;
            loop_phase_error <= 32'sh0;
            trigger_fire     <= 4'h0;
            serial_start     <= 1'b0;
        end else begin
            avs_waitrequest  <= next_wait;
            avs_readdata     <= next_rdata;
            count_reset      <= next_count_reset;
            index_rise       <= next_index_rise;
            gate_en          <= next_gate_en;
            gate_low         <= next_gate_low;
            step_dir         <= next_step_dir;
            filter_en        <= next_filter_en;
            latch_sel        <= next_latch_sel;
            base_period      <= next_base_period;
            time_const       <= next_time_const;
            phase_limit      <= next_phase_limit;
            prescale         <= next_prescale;
            serial_sel       <= next_serial_sel;
            trigger_offset_us <= next_trigger_offset_us;
            {prev_a, prev_b, prev_idx} <= {pin_if.clean[0], pin_if.clean[1], pin_if.clean[2]};
            {arm, seen}      <= {next_arm, next_seen};
            count            <= next_count;
            total            <= next_total;
            held             <= next_held;
            pre_cnt          <= next_pre_cnt;
            phase            <= next_phase;
            trim             <= next_trim;
            acc              <= next_acc;
            loop_phase_error <= next_loop_phase_error;
            trigger_fire     <= next_fire;
            serial_start     <= next_serial;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_FIRE_AT_TARGET: assert property (trigger_fire[0] |-> $past(phase) == $past(tgt[0])) // RQ1
        else $error("Timer one fired away from its target phase");
    AST_FREE_RUN: assert property ((phase_limit == 32'h0) |=> (trim == 32'sh0)) // RQ2
        else $error("Trim moved while free-running");
    AST_TRIM_ON_READ: assert property ((trim != $past(trim) // RQ3
        && $past(phase_limit, 2) == $past(phase_limit)) |-> $past(rd_cnt_ev))
        else $error("Trim changed without a host read");
    AST_PRESCALE_TICK: assert property ((phase != $past(phase) && !$past(rd_cnt_ev)) // RQ4
        |-> $past(tick)) else $error("Phase advanced without a rate tick");
    AST_ERR_REPORT: assert property (rd_cnt_ev |=> loop_phase_error == $past(err) / 20) // RQ5
        else $error("Phase error not reported after host read");
    AST_SERIAL_START: assert property (serial_start == trigger_fire[$past(serial_sel)]) // RQ6
        else $error("Serial start does not follow its timer");
    AST_TIMER_LATCH: assert property (($past(latch_sel) == 3'h1 && $past(trigger_fire[0])) // RQ20
        |-> held == $past(count)) else $error("Count not latched on timer one");
    AST_COUNT_HOLD: assert property (count_reset |=> count == 32'sh0) // RQ10
        else $error("Count not held at zero");
    AST_INDEX_ZERO: assert property ((arm && idx_q && !count_reset && !(wr && wa == 6'h00)) // RQ11
        |=> (count == 32'sh0 && !arm && seen)) else $error("Armed index did not zero count");
    AST_TOTAL_FREE: assert property (total == $past(total) + $past(delta)) // RQ12
        else $error("Total count disturbed");
    AST_BUS_ONE_WAIT: assert property (((avs_read || avs_write) && avs_waitrequest) // Bus wait state, outside the RQ list
        |=> !avs_waitrequest) else $error("Bus answer late");
endmodule : ecwtl_top

// ===== testbench/ecwtl_enc_model.sv
// Purpose: Encoder model driving A, B, index and index mask
// Assumes: Lines change just after a rising clk_sys edge
// Notes:   Lines are always driven, never released
`timescale 1ns/1ps
module ecwtl_enc_model (
    // Clock
    input  wire logic clk_sys,
    // Encoder lines
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_index,
    output logic      enc_index_mask
);
    logic [3:0] pins = 4'h0;
    logic [1:0] ph   = 2'h0;
    assign {enc_index_mask, enc_index, enc_b, enc_a} = pins;
    task automatic put(input logic [3:0] v, input int n);
        @(posedge clk_sys);
        pins <= v;
        repeat (n) @(posedge clk_sys);
    endtask : put
    // Forward motion has A leading B
    task automatic move(input int steps);
        repeat (steps < 0 ? -steps : steps) begin
            ph = (steps < 0) ? ph - 2'h1 : ph + 2'h1;
            put({pins[3:2], ph[1], ph[1] ^ ph[0]}, 20);
        end
    endtask : move
    task automatic pulse(input int bitn, input int w);
        put(pins ^ (4'h1 << bitn), w);
        put(pins ^ (4'h1 << bitn), w);
    endtask : pulse
    task automatic mask(input logic v);
        put({v, pins[2:0]}, 20);
    endtask : mask
endmodule : ecwtl_enc_model

// ===== testbench/tb_encoder_counter_with_timed_latch.sv
// Purpose: Self-checking bench for the encoder counter with timed latch
// Assumes: Avalon-MM master tasks, encoder model on the pins
// Notes:   Base period shortened to 4000 cycles
`timescale 1ns/1ps
module tb_encoder_counter_with_timed_latch;
    logic        clk_sys;
    logic        rst;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata, q, c0;
    logic        avs_waitrequest, enc_a, enc_b, enc_index, enc_index_mask, serial_start;
    logic [3:0]  trigger_fire;
    int          fails = 0, tests_run = 0, n;
    int          offs [4] = '{-100, -50, -25, 10};
    ecwtl_top #(.BASE_PERIOD_DEF(4000)) dut (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .enc_a(enc_a), .enc_b(enc_b),
        .enc_index(enc_index), .enc_index_mask(enc_index_mask),
        .trigger_fire(trigger_fire), .serial_start(serial_start));
    ecwtl_enc_model enc (.clk_sys(clk_sys), .enc_a(enc_a), .enc_b(enc_b),
        .enc_index(enc_index), .enc_index_mask(enc_index_mask));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 100);
        if (k >= 100) begin
            fails++;
            complete_run();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [5:0] ad, input string nm, input logic [31:0] exp);
        bus(1'b0, ad, 32'h0);
        chk(nm, exp, q);
    endtask : rd
    task automatic wait_fire(input int j, output int m);
        m = 0;
        do begin
            @(negedge clk_sys);
            m++;
        end while (trigger_fire[j] !== 1'b1 && m < 5000);
        if (m >= 5000) begin
            fails++;
            complete_run();
        end
    endtask : wait_fire
    initial begin
        rst <= 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} <= '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ecwtl_pkg::ADDR_CTRL, "ctrl", 32'h40);
        rd(ecwtl_pkg::ADDR_TIME_CONST, "tconst", 32'h7d0);
        rd(ecwtl_pkg::ADDR_PHASE_LIMIT, "plimit", 32'h40_0000);
        rd(ecwtl_pkg::ADDR_PRESCALE, "prescale", 32'h1);
        rd(ecwtl_pkg::ADDR_BASE_PERIOD, "base", 32'hfa0);
        rd(6'h3c, "unmapped", 32'h0);
        bus(1'b0, ecwtl_pkg::ADDR_LATCH_SEL, 32'h0);
        chk("latch_sel", 32'h7, {29'h0, q[2:0]});
        enc.move(8);
        rd(ecwtl_pkg::ADDR_COUNT, "count", 32'h8);
        enc.move(-3);
        rd(ecwtl_pkg::ADDR_COUNT, "count", 32'h5);
        bus(1'b1, ecwtl_pkg::ADDR_CTRL, 32'h41);
        enc.move(2);
        rd(ecwtl_pkg::ADDR_COUNT, "count", 32'h0);
        rd(ecwtl_pkg::ADDR_TOTAL, "total", 32'h7);
        bus(1'b1, ecwtl_pkg::ADDR_CTRL, 32'h46);
        enc.move(4);
        enc.pulse(2, 25);
        rd(ecwtl_pkg::ADDR_CTRL, "ctrl", 32'hc4);
        rd(ecwtl_pkg::ADDR_COUNT, "count", 32'h0);
        rd(ecwtl_pkg::ADDR_TOTAL, "total", 32'hb);
        enc.move(-1);
        rd(ecwtl_pkg::ADDR_COUNT, "count", 32'hffff_ffff);
        bus(1'b1, ecwtl_pkg::ADDR_CTRL, 32'hce);
        enc.pulse(2, 25);
        rd(ecwtl_pkg::ADDR_CTRL, "ctrl", 32'h4e);
        enc.mask(1'b1);
        enc.pulse(2, 25);
        rd(ecwtl_pkg::ADDR_CTRL, "ctrl", 32'hcc);
        rd(ecwtl_pkg::ADDR_COUNT, "count", 32'h0);
        bus(1'b1, ecwtl_pkg::ADDR_CTRL, 32'hde);
        enc.pulse(2, 25);
        rd(ecwtl_pkg::ADDR_CTRL, "ctrl", 32'h5e);
        enc.mask(1'b0);
        enc.pulse(2, 25);
        rd(ecwtl_pkg::ADDR_CTRL, "ctrl", 32'hdc);
        bus(1'b1, ecwtl_pkg::ADDR_PHASE_LIMIT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ecwtl_pkg::ADDR_OFFSET0 + 6'(4 * i), 32'(offs[i]));
        end
        wait_fire(0, n);
        wait_fire(0, n);
        chk("period", 32'd4000, 32'(n));
        chk("serial", 32'h1, {31'h0, serial_start});
        bus(1'b0, ecwtl_pkg::ADDR_COUNT, 32'h0);
        rd(ecwtl_pkg::ADDR_PHASE_ERR, "phase_err", 32'hffff_ff9d);
        bus(1'b1, ecwtl_pkg::ADDR_SERIAL_SEL, 32'h2);
        for (int j = 1; j < 4; j++) begin
            wait_fire(0, n);
            wait_fire(j, n);
            chk("timer", 32'((offs[j] + 100) * 20), 32'(n));
            chk("serial", 32'(j == 2), {31'h0, serial_start});
        end
        bus(1'b0, ecwtl_pkg::ADDR_COUNT, 32'h0);
        c0 = q;
        bus(1'b1, ecwtl_pkg::ADDR_LATCH_SEL, 32'h1);
        wait_fire(0, n);
        enc.move(1);
        rd(ecwtl_pkg::ADDR_COUNT, "held", c0);
        bus(1'b1, ecwtl_pkg::ADDR_LATCH_SEL, 32'h0);
        bus(1'b1, ecwtl_pkg::ADDR_SYNC, 32'h0);
        enc.move(1);
        rd(ecwtl_pkg::ADDR_COUNT, "held", c0 + 32'h1);
        bus(1'b1, ecwtl_pkg::ADDR_LATCH_SEL, 32'h7);
        rd(ecwtl_pkg::ADDR_COUNT, "live", c0 + 32'h2);
        bus(1'b1, ecwtl_pkg::ADDR_CTRL, 32'h60);
        enc.put(4'h2, 20);
        bus(1'b0, ecwtl_pkg::ADDR_COUNT, 32'h0);
        c0 = q;
        enc.pulse(0, 25);
        enc.pulse(0, 10);
        rd(ecwtl_pkg::ADDR_COUNT, "step", c0 + 32'h1);
        bus(1'b1, ecwtl_pkg::ADDR_CTRL, 32'h20);
        enc.pulse(0, 10);
        rd(ecwtl_pkg::ADDR_COUNT, "step", c0 + 32'h2);
        complete_run();
    end
endmodule : tb_encoder_counter_with_timed_latch
